// >>> logic/wdsup_params.svh
// Purpose: Constants of the watchdog supervisor: codes, offsets, timing.
// Assumes: Included by bare name from design files under logic/.
// Notes:   Definitions only; no logic here.
`ifndef WDSUP_PARAMS_SVH
`define WDSUP_PARAMS_SVH

`define WDSUP_ADDR_CTRL        7'h00
`define WDSUP_ADDR_MODE        7'h01
`define WDSUP_ADDR_STATUS      7'h05
`define WDSUP_ADDR_NVCFG       7'h74

`define WDSUP_WM_AUTO          3'h1
`define WDSUP_WM_TIMEOUT       3'h2
`define WDSUP_WM_WINDOW        3'h4

`define WDSUP_OP_SLEEP         3'h1
`define WDSUP_OP_STANDBY       3'h4
`define WDSUP_OP_NORMAL        3'h7

`define WDSUP_PH_OFF           2'h0
`define WDSUP_PH_FIRST         2'h1
`define WDSUP_PH_SECOND        2'h2

`define WDSUP_NWP_DEFAULT      4'h4
`define WDSUP_NV_PRESET        8'h08
`define WDSUP_RSS_ILLEGAL_WMC  5'h10
`define WDSUP_RSS_EARLY        5'h0E
`define WDSUP_RSS_OVERFLOW     5'h0F

`define WDSUP_TICK_US          1000
`define WDSUP_CLK_MHZ          100
`define WDSUP_TICK_CYC         (`WDSUP_TICK_US * `WDSUP_CLK_MHZ)

`endif

// >>> logic/wdsup_pkg.sv
// Purpose: Types of the watchdog supervisor.
// Assumes: Nothing beyond the params header.
// Notes:   Effective behaviour enumeration shared by both modules.
`default_nettype none
package wdsup_pkg;
    typedef enum logic [1:0] {
        WDSUP_EFF_OFF     = 2'h0,
        WDSUP_EFF_TIMEOUT = 2'h1,
        WDSUP_EFF_WINDOW  = 2'h3
    } wdsup_eff_t;
endpackage
`default_nettype wire

// >>> logic/wdsup_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin input.
// Assumes: Input asynchronous to sys_clk_i.
// Notes:   The first stage feeds only the second stage.
`default_nettype none
module wdsup_sync (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    input  wire logic init_i,
    output logic      level_o
);
    import wdsup_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } wdsup_sync_st_t;

    wdsup_sync_st_t cur_ff;
    wdsup_sync_st_t nxt_cur;

    // Shift the pin and accept a new level once stages two and three agree.
    always_comb begin
        nxt_cur    = cur_ff;
        nxt_cur.s1 = async_i ^ init_i;
        nxt_cur.s2 = cur_ff.s1;
        nxt_cur.s3 = cur_ff.s2;
        if (cur_ff.s2 == cur_ff.s3) begin
            nxt_cur.lvl = cur_ff.s3;
        end
    end

    // Stages hold the pin relative to its idle level, so a zero reset means idle, no false edge.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Restore the true pin polarity.
    assign level_o = cur_ff.lvl ^ init_i;
endmodule
`default_nettype wire

// >>> logic/wdsup_top.sv
// Purpose: Watchdog supervisor of a system basis chip: mode resolution, timing, status.
// Assumes: Register writes arrive as decoded one-cycle strobes from the serial slave.
// Notes:   Period ticks are 1 ms enables from a divider on sys_clk_i.
// Function
// - Invalid mode or period code aborts write.
// - Valid codes differ in at least two bits.
// - Forced normal keeps watchdog disabled.
// - Window only with Window code in Normal.
// - Timeout code runs in Normal/Standby/Sleep.
// - Window code falls back to timeout.
// - Autonomous: timeout Normal, Standby with pin low.
// - Development mode resets to Autonomous code.
// - Development plus Autonomous keeps watchdog off.
// - Window from Standby activates in Normal.
// - Window overflow or early trigger resets.
// - Late window trigger restarts the timer.
// - Timeout trigger anytime restarts timer.
// - Timeout overflow sets interrupt flag.
// - Overflow with pending flag resets system.
// - Overflow in Sleep raises wake-up.
// - Two-bit phase status off/first/second.
// - Status bits show forced/development active.
// - Nonvolatile enables preset forced on, development off.
// - Start-up threshold code copies to selection.
// - Sleep-support bit gates Sleep availability.
// - Valid control write restarts timer immediately.
// - Eight periods 8..4096 ms, default 128.
// - Mode change in Normal resets with code.
// - Accepted control write sets phase to first half, off if disabled.
`include "wdsup_params.svh"
`default_nettype none
module wdsup_top #(
    parameter int unsigned TICK_CYC = `WDSUP_TICK_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       wr_stb_i,
    input  wire logic [6:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       nv_wr_unlock_i,
    input  wire logic [2:0] op_mode_i,
    input  wire logic       first_irq_pin_n_i,
    input  wire logic       wd_irq_clear_i,
    input  wire logic       spi_fail_irq_en_i,
    output logic [7:0]      watchdog_state_report_o,
    output logic [7:0]      nonvolatile_chip_config_o,
    output logic [7:0]      wd_ctrl_o,
    output logic            wd_overflow_irq_o,
    output logic            spi_fail_irq_o,
    output logic            sys_reset_o,
    output logic [4:0]      reset_source_code_o,
    output logic            wake_o,
    output logic [1:0]      main_reg_uv_threshold_o,
    output logic            sleep_support_disable_o
);
    import wdsup_pkg::*;

    typedef struct packed {
        logic [2:0]  wd_mode_select;
        logic [3:0]  wd_period_select;
        logic [7:0]  nvcfg;
        logic [1:0]  phase;
        logic [12:0] ms;
        logic [16:0] div;
        logic        irq;
        logic        spi_fail;
        logic        rst_req;
        logic [4:0]  reset_source_code;
        logic        wake;
        logic [1:0]  uv_sel;
        logic        started;
    } wdsup_st_t;

    wdsup_st_t  cur_ff;
    wdsup_st_t  nxt_cur;
    logic       pin_n;
    wdsup_eff_t eff;

    // Returns the period in ms for a valid code, zero for an illegal code.
    function automatic logic [12:0] period_ms(input logic [3:0] c);
        unique case (c)
            4'h8:    period_ms = 13'h0008;
            4'h1:    period_ms = 13'h0010;
            4'h2:    period_ms = 13'h0020;
            4'hB:    period_ms = 13'h0040;
            4'h4:    period_ms = 13'h0080;
            4'hD:    period_ms = 13'h0100;
            4'hE:    period_ms = 13'h0400;
            4'h7:    period_ms = 13'h1000;
            default: period_ms = 13'h0000;
        endcase
    endfunction

    // True when the mode code is one of the three defined codes.
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == `WDSUP_WM_AUTO) || (m == `WDSUP_WM_TIMEOUT) ||
                  (m == `WDSUP_WM_WINDOW);
    endfunction

    // Pin idles high, so the synchroniser starts from its reset level then follows.
    wdsup_sync u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (first_irq_pin_n_i),
        .init_i    (1'b1),
        .level_o   (pin_n)
    );

    logic forced_normal_operation;
    logic sw_development_operation;
    assign forced_normal_operation = cur_ff.nvcfg[3];
    assign sw_development_operation = cur_ff.nvcfg[2];

    // Resolve the effective watchdog behaviour from code, chip mode and settings.
    always_comb begin
        eff = WDSUP_EFF_OFF;
        if (forced_normal_operation) begin
            eff = WDSUP_EFF_OFF;
        end else if (op_mode_i == `WDSUP_OP_NORMAL) begin
            if (cur_ff.wd_mode_select == `WDSUP_WM_WINDOW) eff = WDSUP_EFF_WINDOW;
            else if (cur_ff.wd_mode_select == `WDSUP_WM_TIMEOUT) eff = WDSUP_EFF_TIMEOUT;
            else if (!sw_development_operation) eff = WDSUP_EFF_TIMEOUT;
        end else if (op_mode_i == `WDSUP_OP_STANDBY || op_mode_i == `WDSUP_OP_SLEEP) begin
            if (cur_ff.wd_mode_select != `WDSUP_WM_AUTO) eff = WDSUP_EFF_TIMEOUT;
            else if (!sw_development_operation && op_mode_i == `WDSUP_OP_STANDBY && !pin_n)
                eff = WDSUP_EFF_TIMEOUT;
        end
    end

    logic [12:0] per;
    logic [12:0] half;
    logic        tick;
    logic        is_ctrl;
    logic        ok_wr;
    logic        trig_ok;
    assign per  = period_ms(cur_ff.wd_period_select);
    assign half = per >> 1;
    assign tick = (cur_ff.div == 17'(TICK_CYC - 1));
    assign is_ctrl = wr_stb_i && (wr_addr_i == `WDSUP_ADDR_CTRL);
    assign ok_wr = mode_ok(wr_data_i[7:5]) && (period_ms(wr_data_i[3:0]) != 13'h0000);
    // A valid write that neither changes the mode in Normal nor comes early restarts the timer.
    assign trig_ok = is_ctrl && ok_wr &&
                     !(op_mode_i == `WDSUP_OP_NORMAL && wr_data_i[7:5] != cur_ff.wd_mode_select) &&
                     !(eff == WDSUP_EFF_WINDOW && cur_ff.phase == `WDSUP_PH_FIRST);

    // Next-state logic for configuration, timer, flags and resets.
    always_comb begin
        nxt_cur         = cur_ff;
        nxt_cur.rst_req = 1'b0;
        nxt_cur.wake    = 1'b0;
        nxt_cur.spi_fail = 1'b0;
        nxt_cur.div     = tick ? 17'h0 : cur_ff.div + 17'h1;
        if (!cur_ff.started) begin
            nxt_cur.started = 1'b1;
            nxt_cur.uv_sel  = cur_ff.nvcfg[5:4];
        end
        // Timer advance and phase tracking; a trigger in the end cycle still counts in time.
        if (eff == WDSUP_EFF_OFF) begin
            nxt_cur.ms    = 13'h0;
            nxt_cur.phase = `WDSUP_PH_OFF;
        end else if (!trig_ok) begin
            if (cur_ff.phase == `WDSUP_PH_OFF) nxt_cur.phase = `WDSUP_PH_FIRST;
            if (tick) nxt_cur.ms = cur_ff.ms + 13'h1;
            if (tick && (cur_ff.ms + 13'h1) >= half) nxt_cur.phase = `WDSUP_PH_SECOND;
            if (tick && (cur_ff.ms + 13'h1) >= per) begin
                nxt_cur.ms    = 13'h0;
                nxt_cur.phase = `WDSUP_PH_FIRST;
                if (op_mode_i == `WDSUP_OP_SLEEP) nxt_cur.wake = 1'b1;
                if (eff == WDSUP_EFF_WINDOW) begin
                    nxt_cur.rst_req = 1'b1;
                    nxt_cur.reset_source_code     = `WDSUP_RSS_OVERFLOW;
                end else if (cur_ff.irq) begin
                    nxt_cur.rst_req = 1'b1;
                    nxt_cur.reset_source_code     = `WDSUP_RSS_OVERFLOW;
                end else begin
                    nxt_cur.irq = 1'b1;
                end
            end
        end
        // Flag clear loses against a set in the same cycle.
        if (wd_irq_clear_i && !(nxt_cur.irq && !cur_ff.irq)) nxt_cur.irq = 1'b0;
        // Control register write acts as trigger.
        if (is_ctrl) begin
            if (!ok_wr) begin
                nxt_cur.spi_fail = spi_fail_irq_en_i;
            end else if (op_mode_i == `WDSUP_OP_NORMAL &&
                         wr_data_i[7:5] != cur_ff.wd_mode_select) begin
                nxt_cur.rst_req = 1'b1;
                nxt_cur.reset_source_code     = `WDSUP_RSS_ILLEGAL_WMC;
            end else if (eff == WDSUP_EFF_WINDOW && cur_ff.phase == `WDSUP_PH_FIRST) begin
                nxt_cur.rst_req = 1'b1;
                nxt_cur.reset_source_code     = `WDSUP_RSS_EARLY;
            end else begin
                nxt_cur.wd_mode_select   = wr_data_i[7:5];
                nxt_cur.wd_period_select = wr_data_i[3:0];
                nxt_cur.ms               = 13'h0;
                nxt_cur.div              = 17'h0;
                nxt_cur.phase            = (eff == WDSUP_EFF_OFF) ? `WDSUP_PH_OFF : `WDSUP_PH_FIRST;
            end
        end
        if (wr_stb_i && wr_addr_i == `WDSUP_ADDR_NVCFG && nv_wr_unlock_i) begin
            nxt_cur.nvcfg = {2'b00, wr_data_i[5:0]};
        end
        if (nxt_cur.rst_req) begin
            nxt_cur.wd_mode_select   = sw_development_operation ? `WDSUP_WM_AUTO : `WDSUP_WM_TIMEOUT;
            nxt_cur.wd_period_select = `WDSUP_NWP_DEFAULT;
            nxt_cur.ms               = 13'h0;
            nxt_cur.phase            = `WDSUP_PH_OFF;
            nxt_cur.started          = 1'b0;
        end
    end

    // State register; the nonvolatile image restores its factory preset on reset.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff                  <= '0;
            cur_ff.wd_mode_select   <= `WDSUP_WM_TIMEOUT;
            cur_ff.wd_period_select <= `WDSUP_NWP_DEFAULT;
            cur_ff.nvcfg            <= `WDSUP_NV_PRESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from the state register.
    // phase status field
    assign watchdog_state_report_o   = {4'h0, forced_normal_operation, sw_development_operation, cur_ff.phase};
    assign nonvolatile_chip_config_o = cur_ff.nvcfg;
    assign wd_ctrl_o               = {cur_ff.wd_mode_select, 1'b0, cur_ff.wd_period_select};
    assign wd_overflow_irq_o       = cur_ff.irq;
    assign spi_fail_irq_o          = cur_ff.spi_fail;
    assign sys_reset_o             = cur_ff.rst_req;
    assign reset_source_code_o     = cur_ff.reset_source_code;
    assign wake_o                  = cur_ff.wake;
    assign main_reg_uv_threshold_o = cur_ff.uv_sel;
    assign sleep_support_disable_o = cur_ff.nvcfg[0];

    // Window code only gives window behaviour in Normal.
    chk_window_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (eff == WDSUP_EFF_WINDOW) |-> (op_mode_i == `WDSUP_OP_NORMAL && !forced_normal_operation))
        else $error("window outside normal");
    // Forced normal leaves the phase off one cycle later.
    chk_forced_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (forced_normal_operation && $stable(cur_ff.nvcfg)) |=> (cur_ff.phase == `WDSUP_PH_OFF))
        else $error("watchdog runs in forced normal");
    // Illegal writes never change the stored codes.
    chk_bad_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (is_ctrl && !ok_wr && !cur_ff.rst_req && !wd_irq_clear_i)
        |=> $stable(wd_ctrl_o))
        else $error("invalid code stored");
    // A mode change in Normal forces reset with the illegal-access code.
    chk_mode_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (is_ctrl && ok_wr && op_mode_i == `WDSUP_OP_NORMAL &&
         wr_data_i[7:5] != cur_ff.wd_mode_select)
        |=> (sys_reset_o && reset_source_code_o == `WDSUP_RSS_ILLEGAL_WMC))
        else $error("mode change in normal not reset");
    // Early window trigger resets with the early code.
    chk_early_trig: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (is_ctrl && ok_wr && eff == WDSUP_EFF_WINDOW && cur_ff.phase == `WDSUP_PH_FIRST &&
         wr_data_i[7:5] == cur_ff.wd_mode_select)
        |=> (sys_reset_o && reset_source_code_o == `WDSUP_RSS_EARLY))
        else $error("early trigger not reset");
    // An accepted trigger restarts at the first half.
    chk_trig_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (is_ctrl && ok_wr && op_mode_i != `WDSUP_OP_NORMAL && eff != WDSUP_EFF_OFF)
        |=> (cur_ff.ms == 13'h0 && cur_ff.phase == `WDSUP_PH_FIRST))
        else $error("trigger did not restart");
    // Second overflow with a pending flag resets the system.
    chk_second_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (eff == WDSUP_EFF_TIMEOUT && cur_ff.irq && !wd_irq_clear_i && tick &&
         cur_ff.ms + 13'h1 >= per && !is_ctrl) |=> sys_reset_o)
        else $error("pending overflow not reset");
    // Development with autonomous code never runs.
    chk_dev_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sw_development_operation && cur_ff.wd_mode_select == `WDSUP_WM_AUTO) |-> (eff == WDSUP_EFF_OFF))
        else $error("watchdog runs in development");
endmodule
`default_nettype wire

// >>> verification/wdsup_host_model.sv
// Purpose: Host model that issues decoded register writes to the watchdog supervisor.
// Assumes: One write per call, strobe high for exactly one clock.
// Notes:   Idle address and data show the inverse of the last value sent.
`default_nettype none
module wdsup_host_model (
    input  wire logic       sys_clk_i,
    output logic            wr_stb_o,
    output logic [6:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic            nv_wr_unlock_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is idle at time zero.
    initial begin
        wr_stb_o       = 1'b0;
        wr_addr_o      = 7'h7F;
        wr_data_o      = 8'hFF;
        nv_wr_unlock_o = 1'b0;
    end

    // host write sequence.
    // Launches one write after an edge and releases it after the sampling edge.
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic unl);
        @(posedge sys_clk_i);
        wr_stb_o       <= 1'b1;
        wr_addr_o      <= a;
        wr_data_o      <= d;
        nv_wr_unlock_o <= unl;
        @(posedge sys_clk_i);
        wr_stb_o       <= 1'b0;
        wr_addr_o      <= ~a;
        wr_data_o      <= ~d;
        nv_wr_unlock_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench of the watchdog supervisor.
// Assumes: TICK_CYC of 10, so the 8 ms period lasts 80 clocks.
// Notes:   Pulse outputs are matched against a queue of expected events.
`include "wdsup_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic [2:0] op_mode;
    logic       pin_n, irq_clr, fail_en;
    wire logic  wr_stb, nv_unl;
    wire logic [6:0] wr_addr;
    wire logic [7:0] wr_data;
    logic [7:0] status, nvcfg, ctrl;
    logic       irq, fail, sysrst, wake, slpdis;
    logic [4:0] rsc;
    logic [1:0] uvth;
    logic [7:0] evq[$];
    logic [31:0] seed = 32'h6b6682e6;
    int         num_errors = 0;
    int         compares = 0;

    // Free-running 100 MHz clock.
    always #5 sys_clk_i = ~sys_clk_i;

    wdsup_host_model i_wdsup_host_model (.sys_clk_i(sys_clk_i), .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .nv_wr_unlock_o(nv_unl));

    wdsup_top #(.TICK_CYC(10)) i_wdsup_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .wr_stb_i(wr_stb), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .nv_wr_unlock_i(nv_unl), .op_mode_i(op_mode), .first_irq_pin_n_i(pin_n),
        .wd_irq_clear_i(irq_clr), .spi_fail_irq_en_i(fail_en),
        .watchdog_state_report_o(status), .nonvolatile_chip_config_o(nvcfg),
        .wd_ctrl_o(ctrl), .wd_overflow_irq_o(irq), .spi_fail_irq_o(fail),
        .sys_reset_o(sysrst), .reset_source_code_o(rsc), .wake_o(wake),
        .main_reg_uv_threshold_o(uvth), .sleep_support_disable_o(slpdis));

    // Xorshift source of random values.
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic bit ok(input logic [7:0] d);
        return (d[7:5] inside {3'h1, 3'h2, 3'h4}) &&
               (d[3:0] inside {4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7});
    endfunction

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim();
        $display("Errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Waits for an empty event queue (q set) or the overflow flag, within n clocks.
    task automatic wait_on(input int n, input bit q);
        int i;
        for (i = 0; i < n; i++) begin
            if (q ? evq.size() == 0 : irq === 1'b1) break;
            @(posedge sys_clk_i);
        end
        #1;
        if (i == n) begin
            num_errors++;
            $display("MISMATCH wait expected event seen none");
            end_sim();
        end
    endtask

    task automatic wc(input logic [7:0] d);
        i_wdsup_host_model.wr(`WDSUP_ADDR_CTRL, d, 1'b0);
        cyc(1);
    endtask

    task automatic opm(input logic [2:0] m);
        @(posedge sys_clk_i);
        op_mode <= m;
    endtask

    // Resets in Standby and clears the forced normal enable.
    task automatic init();
        @(posedge sys_clk_i);
        rst_i   <= 1'b1;
        op_mode <= `WDSUP_OP_STANDBY;
        pin_n   <= 1'b1;
        irq_clr <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        i_wdsup_host_model.wr(`WDSUP_ADDR_NVCFG, 8'h00, 1'b1);
        cyc(1);
    endtask

    // Every pulse output is matched with the oldest expected event.
    always @(posedge sys_clk_i) begin
        if (!rst_i && (sysrst === 1'b1 || fail === 1'b1 || wake === 1'b1)) begin
            chk("event", {5'h0, sysrst, fail, wake}, evq.size() ? evq.pop_front() : 8'h00);
        end
    end

    initial begin
        logic [7:0] d, exp;
        logic [31:0] r;
        op_mode = `WDSUP_OP_STANDBY;
        pin_n   = 1'b1;
        irq_clr = 1'b0;
        fail_en = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        cyc(2);
        chk("ctrl", ctrl, 8'h44);
        chk("nvcfg", nvcfg, 8'h08);
        chk("status", status, 8'h08);
        chk("uvth", {6'h0, uvth}, 8'h00);
        i_wdsup_host_model.wr(`WDSUP_ADDR_NVCFG, 8'h01, 1'b0);
        cyc(1);
        chk("nvcfg", nvcfg, 8'h08);
        i_wdsup_host_model.wr(`WDSUP_ADDR_NVCFG, 8'h01, 1'b1);
        cyc(1);
        chk("slpdis", {7'h0, slpdis}, 8'h01);
        chk("forced", {7'h0, status[3]}, 8'h00);
        // Every mode code, then every period code, with a random interrupt enable.
        init();
        exp = 8'h44;
        for (int i = 0; i < 24; i++) begin
            d = (i < 8) ? {i[2:0], 5'h08} : (8'h40 | 8'(i - 8));
            r = rnd();
            @(posedge sys_clk_i);
            fail_en <= r[0];
            pin_n   <= r[1];
            irq_clr <= r[2];
            if (ok(d)) exp = d;
            else if (r[0]) evq.push_back(8'h02);
            wc(d);
            chk("ctrl", ctrl, exp);
        end
        // Timeout mode: random trigger, then overflow flag, then reset.
        init();
        wc(8'h48);
        chk("status", status, 8'h01);
        r = rnd();
        cyc(20 + int'(r[4:0]));
        wc(8'h48);
        chk("status", status, 8'h01);
        chk("irq", {7'h0, irq}, 8'h00);
        wait_on(100, 1'b0);
        chk("irq", {7'h0, irq}, 8'h01);
        evq.push_back(8'h04);
        wait_on(100, 1'b1);
        cyc(1);
        chk("rsc", {3'h0, rsc}, 8'h0F);
        // Early trigger in window mode.
        init();
        wc(8'h88);
        opm(`WDSUP_OP_NORMAL);
        evq.push_back(8'h04);
        wc(8'h88);
        wait_on(10, 1'b1);
        cyc(1);
        chk("rsc", {3'h0, rsc}, 8'h0E);
        // Late trigger in window mode, then overflow.
        init();
        wc(8'h88);
        wc(8'h88);
        opm(`WDSUP_OP_NORMAL);
        cyc(50);
        chk("status", status, 8'h02);
        wc(8'h88);
        chk("status", status, 8'h01);
        evq.push_back(8'h04);
        wait_on(100, 1'b1);
        cyc(1);
        chk("rsc", {3'h0, rsc}, 8'h0F);
        chk("irq", {7'h0, irq}, 8'h00);
        // Mode change in Normal, with a random start-up threshold in the image.
        init();
        r = rnd();
        i_wdsup_host_model.wr(`WDSUP_ADDR_NVCFG, {2'b00, r[5:4], 4'h0}, 1'b1);
        cyc(1);
        opm(`WDSUP_OP_NORMAL);
        evq.push_back(8'h04);
        wc(8'h88);
        wait_on(10, 1'b1);
        cyc(1);
        chk("rsc", {3'h0, rsc}, 8'h10);
        chk("uvth", {6'h0, uvth}, {6'h0, r[5:4]});
        // Overflow in Sleep wakes the host.
        init();
        wc(8'h48);
        opm(`WDSUP_OP_SLEEP);
        evq.push_back(8'h01);
        wait_on(100, 1'b1);
        cyc(1);
        chk("irq", {7'h0, irq}, 8'h01);
        @(posedge sys_clk_i);
        irq_clr <= 1'b1;
        @(posedge sys_clk_i);
        irq_clr <= 1'b0;
        cyc(1);
        chk("irq", {7'h0, irq}, 8'h00);
        // Autonomous mode, other modes and development mode.
        init();
        wc(8'h28);
        chk("status", status, 8'h00);
        @(posedge sys_clk_i);
        pin_n <= 1'b0;
        cyc(8);
        chk("status", status, 8'h01);
        opm(3'h2);
        cyc(2);
        chk("status", status, 8'h00);
        opm(`WDSUP_OP_STANDBY);
        i_wdsup_host_model.wr(`WDSUP_ADDR_NVCFG, 8'h04, 1'b1);
        cyc(1);
        chk("status", status, 8'h04);
        wc(8'h48);
        chk("status", status, 8'h05);
        // A reset in development mode reloads the autonomous code.
        opm(`WDSUP_OP_NORMAL);
        evq.push_back(8'h04);
        wc(8'h88);
        wait_on(10, 1'b1);
        cyc(1);
        chk("ctrl", ctrl, 8'h24);
        chk("status", status, 8'h04);
        chk("queue", 8'(evq.size()), 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
